// >>> logic/scm_sto_monitor.sv
`timescale 1ns/1ps
module scm_sto_monitor import scm_pkg::*; #(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic clk_i,                              // Device clock, 20 MHz
  input wire logic reset_i,                            // Power-on reset, active high
  input wire logic enable_channel_a_in_i,              // Enable channel A, high = energised
  input wire logic enable_channel_b_in_i,              // Enable channel B, high = energised
  input wire logic run_cmd_i,                          // Run command level, high = run
  input wire logic [SPEED_W-1:0] held_speed_setpoint_i, // Speed setpoint
  output logic torque_enable_o,                        // Power stage enabled
  output logic [SPEED_W-1:0] speed_ref_o,              // Speed reference to the drive
  output logic running_o,                              // Drive running or decelerating
  output logic sto_trip_o,                             // Safe torque off trip indication
  output logic channel_fault_o,                        // Latched channel discrepancy fault
  output logic safe_state_feedback_out_o               // Feedback, on after valid dual request
);
  scm_chan_if ch ();

  scm_tick_div #(.TICKS(TICKS)) u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ch(ch)
  );

  scm_chan_sync u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .chan_a_i(enable_channel_a_in_i),
    .chan_b_i(enable_channel_b_in_i),
    .ch(ch)
  );

  scm_state_t state_ff;
  scm_state_t nxt_state;
  logic torque_ff;
  logic nxt_torque;
  logic [SPEED_W-1:0] speed_ff;
  logic [SPEED_W-1:0] nxt_speed;
  logic running_ff;
  logic nxt_running;
  logic trip_ff;
  logic nxt_trip;
  logic fault_ff;
  logic nxt_fault;
  logic fb_ff;
  logic nxt_fb;
  logic pair_ff;
  logic nxt_pair;
  logic both_off_prev_ff;
  logic run_prev_ff;
  logic [1:0] warm_ff;
  logic [1:0] nxt_warm;
  logic nxt_both_off_prev;

  logic both_on;
  logic both_off;
  logic run_edge;
  logic pair_now;
  logic fault_now;

  always_comb begin
    both_on = ch.a_on && ch.b_on;
    both_off = !ch.a_on && !ch.b_on;
    run_edge = run_cmd_i && !run_prev_ff;
    // Synchroniser holds reset levels for two edges; mark when real levels arrive
    nxt_warm = {warm_ff[0], 1'b1};
    nxt_both_off_prev = both_off && warm_ff[1];
    fault_now = ch.differ && (ch.disc_ms > DISC_FAULT_MS); // [RQ4]
    // Classify the request when the second channel drops
    if (both_off && !both_off_prev_ff) begin
      pair_now = (ch.disc_ms <= DISC_PAIR_MS); // [RQ6]
    end else begin
      pair_now = pair_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_torque = torque_ff;
    nxt_speed = speed_ff;
    nxt_running = running_ff;
    nxt_trip = trip_ff;
    nxt_fault = fault_ff || fault_now; // [RQ4] [RQ5]
    nxt_pair = both_off ? pair_now : 1'b0;
    // On only for a valid dual request; drops the cycle a channel returns
    nxt_fb = both_off && pair_now && !nxt_fault; // [RQ6] [RQ7] [RQ8] [RQ3] [RQ1]
    if (nxt_fault) begin
      nxt_state = SCM_FAULT; // [RQ4]
      nxt_torque = 1'b0;
      nxt_speed = SPEED_ZERO;
      nxt_running = 1'b0;
      nxt_trip = 1'b1;
    end else if (!both_on) begin
      nxt_state = SCM_TRIP; // [RQ2] [RQ11]
      nxt_torque = 1'b0;
      nxt_speed = SPEED_ZERO;
      nxt_running = 1'b0;
      nxt_trip = 1'b1; // [RQ7]
    end else begin
      unique case (state_ff)
        SCM_IDLE: begin
          if (run_edge) begin
            nxt_state = SCM_RUN;
            nxt_torque = 1'b1;
            nxt_running = 1'b1;
            nxt_speed = held_speed_setpoint_i;
          end
        end
        SCM_RUN: begin
          if (!run_cmd_i) begin
            nxt_state = SCM_DECEL; // [RQ10]
          end else begin
            nxt_speed = held_speed_setpoint_i;
          end
        end
        SCM_DECEL: begin
          if (run_edge) begin
            nxt_state = SCM_RUN;
            nxt_speed = held_speed_setpoint_i;
          end else if (speed_ff == SPEED_ZERO) begin
            nxt_state = SCM_IDLE; // [RQ10]
            nxt_torque = 1'b0;
            nxt_running = 1'b0;
          end else if (ch.tick) begin
            // Controlled ramp, torque stays applied
            if (speed_ff > DECEL_STEP) begin
              nxt_speed = speed_ff - DECEL_STEP; // [RQ10]
            end else begin
              nxt_speed = SPEED_ZERO;
            end
          end
        end
        SCM_TRIP: begin
          // Fresh restart request after both channels are back
          if (run_edge) begin
            nxt_state = SCM_RUN; // [RQ3] [RQ9]
            nxt_trip = 1'b0;
            nxt_torque = 1'b1;
            nxt_running = 1'b1;
            nxt_speed = held_speed_setpoint_i;
          end
        end
        SCM_FAULT: begin
          nxt_state = SCM_FAULT; // [RQ4]
        end
        default: begin
          nxt_state = SCM_TRIP;
          nxt_torque = 1'b0;
          nxt_speed = SPEED_ZERO;
          nxt_running = 1'b0;
          nxt_trip = 1'b1;
        end
      endcase
    end
    // Stay at rest until channel levels are real, so power-up shows no false trip
    if (!warm_ff[1]) begin
      nxt_state = SCM_IDLE; // [RQ1]
      nxt_torque = 1'b0;
      nxt_speed = SPEED_ZERO;
      nxt_running = 1'b0;
      nxt_trip = 1'b0; // [RQ1]
      nxt_fault = 1'b0;
      nxt_fb = 1'b0; // [RQ1]
      nxt_pair = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= SCM_IDLE; // [RQ1] [RQ5]
      torque_ff <= 1'b0;
      speed_ff <= SPEED_ZERO;
      running_ff <= 1'b0;
      trip_ff <= 1'b0;
      fault_ff <= 1'b0;
      fb_ff <= 1'b0;
      pair_ff <= 1'b0;
      both_off_prev_ff <= 1'b0;
      run_prev_ff <= 1'b0;
      warm_ff <= 2'b00;
    end else begin
      state_ff <= nxt_state;
      torque_ff <= nxt_torque;
      speed_ff <= nxt_speed;
      running_ff <= nxt_running;
      trip_ff <= nxt_trip;
      fault_ff <= nxt_fault;
      fb_ff <= nxt_fb;
      pair_ff <= nxt_pair;
      both_off_prev_ff <= nxt_both_off_prev;
      run_prev_ff <= run_cmd_i;
      warm_ff <= nxt_warm;
    end
  end

  assign torque_enable_o = torque_ff;
  assign speed_ref_o = speed_ff;
  assign running_o = running_ff;
  assign sto_trip_o = trip_ff;
  assign channel_fault_o = fault_ff;
  assign safe_state_feedback_out_o = fb_ff;
endmodule

// >>> logic/scm_pkg.sv
// Summary of operation
// RQ1 - Power-up with both channels: no error, feedback off
// RQ2 - Any channel loss removes torque, trips at once
// RQ3 - Short single loss: feedback off, restart clears
// RQ4 - Single loss over three seconds latches fault
// RQ5 - Fault clears only by power cycle reset
// RQ6 - Both removed within one second: feedback on
// RQ7 - Both removed: run ignored, trip, feedback on; code sets feedback only if the second channel drops within one second
// RQ8 - Both restored: feedback off, trip stays
// RQ9 - Next restart clears trip, runs held setpoint
// RQ10 - Normal stop ramps down, feedback stays off
// RQ11 - Torque removal well under ten milliseconds
// RQ12 - Inputs synchronised, discrepancy counted while differing
package scm_pkg;
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TICK_PERIOD_US = 1_000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int TICK_CNT_W = 16;

  localparam int DISC_W = 12;
  localparam int PAIR_WINDOW_S = 1;
  localparam int FAULT_TIME_S = 3;
  localparam logic [DISC_W-1:0] DISC_PAIR_MS = DISC_W'(PAIR_WINDOW_S * 1000);
  localparam logic [DISC_W-1:0] DISC_FAULT_MS = DISC_W'(FAULT_TIME_S * 1000);
  localparam logic [DISC_W-1:0] DISC_MAX = 12'hFFF;
  localparam logic [DISC_W-1:0] DISC_ZERO = 12'h000;
  localparam logic [DISC_W-1:0] DISC_ONE = 12'h001;

  localparam int SPEED_W = 16;
  localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000;
  localparam logic [SPEED_W-1:0] DECEL_STEP = 16'h0010;

  typedef enum logic [2:0] {
    SCM_IDLE = 3'b000,
    SCM_RUN = 3'b001,
    SCM_DECEL = 3'b011,
    SCM_TRIP = 3'b010,
    SCM_FAULT = 3'b110
  } scm_state_t;
endpackage

// >>> logic/scm_chan_if.sv
`timescale 1ns/1ps
interface scm_chan_if;
  import scm_pkg::*;
  logic tick;
  logic a_on;
  logic b_on;
  logic differ;
  logic [DISC_W-1:0] disc_ms;
  modport tick_src (output tick);
  modport sync_src (input tick, output a_on, output b_on, output differ, output disc_ms);
  modport mon (input tick, input a_on, input b_on, input differ, input disc_ms);
endinterface

// >>> logic/scm_tick_div.sv
`timescale 1ns/1ps
module scm_tick_div import scm_pkg::*; #(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic clk_i,      // Device clock
  input wire logic reset_i,    // Async reset, active high
  scm_chan_if.tick_src ch      // Millisecond tick out
);
  logic [TICK_CNT_W-1:0] cnt_ff;
  logic [TICK_CNT_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == TICK_CNT_W'(TICKS - 1));
    nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign ch.tick = tick_ff;
endmodule

// >>> logic/scm_chan_sync.sv
`timescale 1ns/1ps
module scm_chan_sync import scm_pkg::*; (
  input wire logic clk_i,      // Device clock
  input wire logic reset_i,    // Async reset, active high
  input wire logic chan_a_i,   // Raw channel A enable
  input wire logic chan_b_i,   // Raw channel B enable
  scm_chan_if.sync_src ch      // Synchronised levels and discrepancy time
);
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [DISC_W-1:0] disc_ff;
  logic [DISC_W-1:0] nxt_disc;

  // Counts ms while channels disagree, saturating; cleared on agreement
  always_comb begin
    nxt_disc = disc_ff;
    if (sync_ff[0] == sync_ff[1]) begin
      nxt_disc = DISC_ZERO; // [RQ12]
    end else if (ch.tick && disc_ff != DISC_MAX) begin
      nxt_disc = disc_ff + DISC_ONE; // [RQ12]
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_ff <= 2'b00;
      sync_ff <= 2'b00;
      disc_ff <= DISC_ZERO;
    end else begin
      meta_ff <= {chan_b_i, chan_a_i}; // [RQ12]
      sync_ff <= meta_ff;
      disc_ff <= nxt_disc;
    end
  end

  assign ch.a_on = sync_ff[0];
  assign ch.b_on = sync_ff[1];
  assign ch.differ = sync_ff[0] ^ sync_ff[1];
  assign ch.disc_ms = disc_ff;
endmodule

// >>> testbench/scm_sto_properties.sv
`timescale 1ns/1ps
module scm_sto_properties import scm_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Power reset
  input wire logic enable_channel_a_in_i, // Channel A
  input wire logic enable_channel_b_in_i, // Channel B
  input wire logic run_cmd_i, // Run command
  input wire logic torque_enable_o, // Torque on
  input wire logic [SPEED_W-1:0] speed_ref_o, // Speed reference
  input wire logic running_o, // Running
  input wire logic sto_trip_o, // Trip
  input wire logic channel_fault_o, // Fault
  input wire logic safe_state_feedback_out_o // Feedback
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic both_on = enable_channel_a_in_i && enable_channel_b_in_i;
  wire logic fb = safe_state_feedback_out_o;
  a_loss_trips: assert property (!both_on |-> ##[1:4] (!torque_enable_o && sto_trip_o))
    else $error("no trip after channel loss");
  a_speed_zero: assert property (!torque_enable_o |-> speed_ref_o == SPEED_ZERO)
    else $error("speed reference without torque");
  a_fault_holds: assert property (channel_fault_o |=> channel_fault_o)
    else $error("fault cleared without power cycle");
  a_fault_blocks: assert property (channel_fault_o |-> (!torque_enable_o && sto_trip_o && !fb))
    else $error("fault state outputs wrong");
  a_fb_trip: assert property (fb |-> (!torque_enable_o && sto_trip_o && !running_o))
    else $error("feedback on while drive active");
  a_fb_release: assert property (both_on [*5] |-> !fb)
    else $error("feedback on with both channels on");
  a_fb_fall_trip: assert property ($fell(fb) |-> sto_trip_o)
    else $error("trip lost when feedback fell");
  a_power_up: assert property ($past(reset_i) |-> (!channel_fault_o && !fb && !torque_enable_o
    && !sto_trip_o))
    else $error("outputs not clear after power up");
  a_restart_runs: assert property ((both_on [*4] ##0 ($rose(run_cmd_i) && !channel_fault_o
    && !running_o)) |=> (running_o && torque_enable_o && !sto_trip_o))
    else $error("restart refused");
  c_fb_on: cover property ($rose(fb));
  c_fault: cover property ($rose(channel_fault_o));
  c_stop: cover property ($fell(running_o) && !sto_trip_o);
endmodule
bind scm_sto_monitor scm_sto_properties u_props (.clk_i, .reset_i, .enable_channel_a_in_i,
  .enable_channel_b_in_i, .run_cmd_i, .torque_enable_o, .speed_ref_o, .running_o,
  .sto_trip_o, .channel_fault_o, .safe_state_feedback_out_o);

// >>> testbench/scm_safety_unit.sv
`timescale 1ns/1ps
module scm_safety_unit (
  input wire logic open_a_i, // Open contact A
  input wire logic open_b_i, // Open contact B
  output logic chan_a_o, // Channel A, high = energised
  output logic chan_b_o // Channel B, high = energised
);
  // Open contact removes the enable voltage
  assign chan_a_o = !open_a_i;
  assign chan_b_o = !open_b_i;
endmodule

// >>> testbench/sto_channel_monitor_bench.sv
`timescale 1ns/1ps
module sto_channel_monitor_bench;
  import scm_pkg::*;
  localparam int TK = 2;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic open_a = 1'b0;
  logic open_b = 1'b0;
  logic run_cmd = 1'b0;
  logic [SPEED_W-1:0] sp = 16'h0000;
  wire logic ch_a;
  wire logic ch_b;
  logic torque, running, trip, fault, fb;
  logic [SPEED_W-1:0] speed;
  int err_count = 0;
  int comparisons = 0;
  integer seed = 32'he6f3_67dc;
  int i;
  int n;
  scm_safety_unit sfu (.open_a_i(open_a), .open_b_i(open_b), .chan_a_o(ch_a), .chan_b_o(ch_b));
  scm_sto_monitor #(.TICKS(TK)) dut (.clk_i, .reset_i, .enable_channel_a_in_i(ch_a),
    .enable_channel_b_in_i(ch_b), .run_cmd_i(run_cmd), .held_speed_setpoint_i(sp),
    .torque_enable_o(torque), .speed_ref_o(speed), .running_o(running), .sto_trip_o(trip),
    .channel_fault_o(fault), .safe_state_feedback_out_o(fb));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] f(input logic r, input logic t, input logic x, input logic p);
    return {r, r, t, x, p};
  endfunction
  task automatic st(input logic [4:0] e);
    chk({11'h000, torque, running, trip, fault, fb}, {11'h000, e});
  endtask
  task automatic restart();
    run_cmd = 1'b0;
    cyc(5);
    run_cmd = 1'b1;
    cyc(3);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sp = 16'($random(seed)) | 16'h0001;
    cyc(16);
    reset_i = 1'b0;
    cyc(4);
    chk(16'({trip, fault, fb}), 16'h0000);
    restart();
    st(f(1, 0, 0, 0));
    chk(speed, sp);
    $display("test power-up done");
    for (i = 0; i < 2; i++) begin
      n = 10 + $unsigned($random(seed)) % (990 * TK);
      open_a = (i == 0);
      open_b = (i == 1);
      cyc(4);
      st(f(0, 1, 0, 0));
      cyc(n);
      st(f(0, 1, 0, 0));
      open_a = 1'b0;
      open_b = 1'b0;
      restart();
      st(f(1, 0, 0, 0));
      open_a = (i == 0);
      open_b = (i == 1);
      cyc(3002 * TK + 10);
      st(f(0, 1, 1, 0));
      open_a = 1'b0;
      open_b = 1'b0;
      restart();
      st(f(0, 1, 1, 0));
      reset_i = 1'b1;
      cyc(2);
      reset_i = 1'b0;
      cyc(1);
      chk(16'({trip, fault, fb}), 16'h0000);
      restart();
      st(f(1, 0, 0, 0));
      $display("test channel %0d done", i);
    end
    // Second channel drops after more than one second: no pair, no fault
    open_a = 1'b1;
    cyc(1500 * TK);
    open_b = 1'b1;
    cyc(5);
    st(f(0, 1, 0, 0));
    open_a = 1'b0;
    open_b = 1'b0;
    restart();
    st(f(1, 0, 0, 0));
    $display("test late pair done");
    open_a = 1'b1;
    cyc(2 + $unsigned($random(seed)) % (800 * TK));
    open_b = 1'b1;
    cyc(5);
    st(f(0, 1, 0, 1));
    run_cmd = 1'b0;
    cyc(2);
    run_cmd = 1'b1;
    cyc(10000 * TK + 10);
    st(f(0, 1, 0, 1));
    run_cmd = 1'b0;
    open_a = 1'b0;
    open_b = 1'b0;
    cyc(5);
    st(f(0, 1, 0, 0));
    restart();
    st(f(1, 0, 0, 0));
    chk(speed, sp);
    $display("test dual request done");
    sp = 16'h0025;
    cyc(2);
    run_cmd = 1'b0;
    cyc(2);
    st(f(1, 0, 0, 0));
    n = 0;
    while (running === 1'b1 && n < 100 * TK) begin
      cyc(1);
      n++;
    end
    if (n == 100 * TK) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, running, 1'b0);
    end
    st(f(0, 0, 0, 0));
    chk(speed, 16'h0000);
    $display("test stop done");
    stop_test();
  end
endmodule
